/* pkg/uptio_map.svh */
// constants for the user port trigger i/o block: register offsets, fields, reset values, timing.
// assumes a 250 MHz system clock and a 32-bit avalon-mm register bus.
// Contract
// - trigger pulses of at least 1 us on either input are valid triggers
// - coax trigger input acts exactly like trigger input one
// - trigger input one starts the triggered measurement on a valid pulse
// - trigger input two is a second independent trigger source
// - ready-for-trigger only after measurement ends and a new trigger is acceptable
// - four channel code outputs come from a per-channel programmable value
// - two outputs report pass or fail of limit checks one and two
// - switch selects drive-port role; on means extra channel bits, default on
// - drive-port role: output i high only while port i is source
// - channel-bit role: drive-port outputs come from a per-channel value
// - an output triggers the external generator during sequenced measurements
// - trigger output behaviour is configurable by software
// - remote group trigger starts the measurement like an external pulse
// - remote device clear resets command processing, keeps settings; here it only resets the channel select to 0
// - go-to-local enters manual state; go-to-remote enters remote state
`ifndef UPTIO_MAP_SVH
`define UPTIO_MAP_SVH

`define UPTIO_CLK_MHZ 250
`define UPTIO_TRIG_MIN_NS 1000
`define UPTIO_TRIG_MIN_CYC ((`UPTIO_TRIG_MIN_NS * `UPTIO_CLK_MHZ + 999) / 1000)

`define UPTIO_REG_CTRL 8'h00
`define UPTIO_REG_STATUS 8'h04
`define UPTIO_REG_CHSEL 8'h08
`define UPTIO_REG_CHTAB 8'h0C
`define UPTIO_REG_RESULT 8'h10
`define UPTIO_REG_SRCPORT 8'h14
`define UPTIO_REG_TRIGOUT 8'h18
`define UPTIO_REG_CMD 8'h1C
`define UPTIO_REG_IRQ_STAT 8'h20
`define UPTIO_REG_IRQ_MASK 8'h24
`define UPTIO_REG_MEAS_LEN 8'h28

// ctrl fields
`define UPTIO_CTRL_ECB 0
`define UPTIO_CTRL_TRIG1_EN 1
`define UPTIO_CTRL_TRIG2_EN 2
`define UPTIO_CTRL_GEN_SEQ 3
`define UPTIO_CTRL_RESET 32'h0000_0007
// cmd fields, write-one pulses
`define UPTIO_CMD_GET 0
`define UPTIO_CMD_DCL 1
`define UPTIO_CMD_LOC 2
`define UPTIO_CMD_REM 3
`define UPTIO_CMD_ABORT 4
// irq bits
`define UPTIO_IRQ_TRIG 0
`define UPTIO_IRQ_DONE 1
`define UPTIO_IRQ_DCL 2
`define UPTIO_IRQ_LOCREM 3
`define UPTIO_IRQ_W 4
// trigout modes
`define UPTIO_TOUT_OFF 2'h0
`define UPTIO_TOUT_BUSY 2'h1
`define UPTIO_TOUT_READY 2'h2
`define UPTIO_TOUT_PULSE 2'h3
`define UPTIO_MEAS_LEN_RESET 32'h0000_0100
`endif

/* pkg/uptio_pkg.sv */
// types for the user port trigger i/o block.
// assumes the constants header is included by the design.
package uptio_pkg;
    typedef enum logic [1:0] {
        UPTIO_IDLE,
        UPTIO_MEASURE,
        UPTIO_GEN_WAIT
    } uptio_state_t;
endpackage : uptio_pkg

/* design/uptio_top.sv */
// user port trigger i/o: trigger inputs, busy/ready, channel bits, limit results, drive ports,
// generator trigger and remote messages, all behind an avalon-mm slave.
// assumes all pin inputs are synchronous to clk_i; remote messages arrive as register writes.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`include "uptio_map.svh"
module uptio_top #(
    parameter int NUM_CH = 16,
    parameter int TRIG_MIN_CYC = `UPTIO_TRIG_MIN_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic trigger_input_one_i,
    input wire logic trigger_input_two_i,
    input wire logic coax_trigger_in_i,
    input wire logic generator_handshake_in_i,
    input wire logic aux_control_in_a_i,
    output logic measure_active_out_o,
    output logic ready_for_trigger_o,
    output logic [3:0] chan_code_o,
    output logic limit_result_one_o,
    output logic limit_result_two_o,
    output logic [3:0] source_port_ind_o,
    output logic generator_trigger_out_o,
    output logic coax_trigger_out_o,
    output logic remote_state_o,
    output logic irq_o
);
    localparam int CHW = $clog2(NUM_CH);
    localparam int PW = $clog2(TRIG_MIN_CYC + 1);

    typedef struct packed {
        uptio_pkg::uptio_state_t state;
        logic [31:0] ctrl;
        logic [CHW-1:0] chsel;
        logic [NUM_CH-1:0][7:0] chtab;
        logic [1:0] result;
        logic [1:0] srcport;
        logic [1:0] tout_mode;
        logic [31:0] meas_len;
        logic [31:0] meas_cnt;
        logic [PW-1:0] w1;
        logic [PW-1:0] w2;
        logic arm1;
        logic arm2;
        logic remote;
        logic [`UPTIO_IRQ_W-1:0] irq_stat;
        logic [`UPTIO_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic busy;
        logic ready;
        logic [3:0] chan;
        logic [3:0] drv;
        logic gen_trig;
        logic tout;
    } uptio_state_s_t;

    uptio_state_s_t st;
    uptio_state_s_t next_st;

    // a pulse counts once it has been high for the full minimum width
    function automatic logic [PW-1:0] uptio_width(input logic lvl, input logic [PW-1:0] w);
        if (!lvl) begin
            return '0;
        end
        if (w == PW'(TRIG_MIN_CYC)) begin
            return w;
        end
        return w + PW'(1);
    endfunction : uptio_width

    function automatic logic [31:0] uptio_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : uptio_merge

    logic req;
    logic wr;
    logic [31:0] cmd;
    logic trig1_lvl;
    logic hit1;
    logic hit2;
    logic get_pulse;
    logic start;
    logic meas_done;
    logic [`UPTIO_IRQ_W-1:0] ev;
    logic [7:0] chv;

    always_comb begin
        next_st = st;
        req = (avs_read_i || avs_write_i) && !st.ack;
        wr = avs_write_i && req;
        cmd = (wr && avs_address_i == `UPTIO_REG_CMD) ? (avs_writedata_i & {{24{1'b0}}, {8{avs_byteenable_i[0]}}})
                                                     : 32'h0000_0000;
        // coax trigger is simply ORed into input one
        trig1_lvl = trigger_input_one_i || coax_trigger_in_i;
        next_st.w1 = uptio_width(trig1_lvl, st.w1);
        next_st.w2 = uptio_width(trigger_input_two_i, st.w2);
        hit1 = st.w1 == PW'(TRIG_MIN_CYC) && st.arm1 && st.ctrl[`UPTIO_CTRL_TRIG1_EN];
        hit2 = st.w2 == PW'(TRIG_MIN_CYC) && st.arm2 && st.ctrl[`UPTIO_CTRL_TRIG2_EN];
        // one trigger per pulse: rearm only after the line falls
        if (st.w1 == PW'(TRIG_MIN_CYC)) begin
            next_st.arm1 = 1'b0;
        end else if (!trig1_lvl) begin
            next_st.arm1 = 1'b1;
        end
        if (st.w2 == PW'(TRIG_MIN_CYC)) begin
            next_st.arm2 = 1'b0;
        end else if (!trigger_input_two_i) begin
            next_st.arm2 = 1'b1;
        end
        get_pulse = cmd[`UPTIO_CMD_GET];
        start = (hit1 || hit2 || get_pulse) && st.state == uptio_pkg::UPTIO_IDLE;
        meas_done = 1'b0;
        next_st.gen_trig = 1'b0;

        unique case (st.state)
            uptio_pkg::UPTIO_IDLE: begin
                if (start) begin
                    next_st.meas_cnt = 32'h0000_0000;
                    if (st.ctrl[`UPTIO_CTRL_GEN_SEQ]) begin
                        next_st.gen_trig = 1'b1;
                        next_st.state = uptio_pkg::UPTIO_GEN_WAIT;
                    end else begin
                        next_st.state = uptio_pkg::UPTIO_MEASURE;
                    end
                end
            end
            uptio_pkg::UPTIO_GEN_WAIT: begin
                // generator must release its handshake before the sweep proceeds
                next_st.gen_trig = 1'b1;
                if (!generator_handshake_in_i) begin
                    next_st.gen_trig = 1'b0;
                    next_st.state = uptio_pkg::UPTIO_MEASURE;
                end
            end
            uptio_pkg::UPTIO_MEASURE: begin
                next_st.meas_cnt = st.meas_cnt + 32'h0000_0001;
                if (st.meas_cnt + 32'h0000_0001 >= st.meas_len) begin
                    meas_done = 1'b1;
                    next_st.state = uptio_pkg::UPTIO_IDLE;
                end
            end
            default: begin
                next_st.state = uptio_pkg::UPTIO_IDLE;
            end
        endcase
        // abort stops the sweep; device clear only resets the channel select
        if (cmd[`UPTIO_CMD_ABORT]) begin
            next_st.state = uptio_pkg::UPTIO_IDLE;
            next_st.gen_trig = 1'b0;
        end

        next_st.busy = next_st.state == uptio_pkg::UPTIO_MEASURE;
        next_st.ready = next_st.state == uptio_pkg::UPTIO_IDLE;

        if (cmd[`UPTIO_CMD_LOC]) begin
            next_st.remote = 1'b0;
        end
        if (cmd[`UPTIO_CMD_REM]) begin
            next_st.remote = 1'b1;
        end

        // register writes
        if (wr) begin
            unique case (avs_address_i)
                `UPTIO_REG_CTRL: next_st.ctrl = uptio_merge(st.ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_000F;
                `UPTIO_REG_CHSEL: next_st.chsel = avs_writedata_i[CHW-1:0];
                `UPTIO_REG_CHTAB: next_st.chtab[st.chsel] = avs_writedata_i[7:0];
                `UPTIO_REG_RESULT: next_st.result = avs_writedata_i[1:0];
                `UPTIO_REG_SRCPORT: next_st.srcport = avs_writedata_i[1:0];
                `UPTIO_REG_TRIGOUT: next_st.tout_mode = avs_writedata_i[1:0];
                `UPTIO_REG_IRQ_MASK: next_st.irq_mask = avs_writedata_i[`UPTIO_IRQ_W-1:0];
                `UPTIO_REG_MEAS_LEN: next_st.meas_len = avs_writedata_i;
                default: begin
                end
            endcase
        end
        // device clear resets the channel select to 0; other settings are kept
        if (cmd[`UPTIO_CMD_DCL]) begin
            next_st.chsel = '0;
        end

        // sticky interrupts; set beats a write-one clear in the same cycle
        ev = '0;
        ev[`UPTIO_IRQ_TRIG] = start;
        ev[`UPTIO_IRQ_DONE] = meas_done;
        ev[`UPTIO_IRQ_DCL] = cmd[`UPTIO_CMD_DCL];
        ev[`UPTIO_IRQ_LOCREM] = cmd[`UPTIO_CMD_LOC] || cmd[`UPTIO_CMD_REM];
        if (wr && avs_address_i == `UPTIO_REG_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~avs_writedata_i[`UPTIO_IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | ev;

        // read mux
        next_st.rdata = 32'h0000_0000;
        if (avs_read_i && req) begin
            unique case (avs_address_i)
                `UPTIO_REG_CTRL: next_st.rdata = st.ctrl;
                `UPTIO_REG_STATUS: next_st.rdata = {26'h000_0000, aux_control_in_a_i, generator_handshake_in_i,
                                                    st.remote, st.ready, st.busy, st.state == uptio_pkg::UPTIO_GEN_WAIT};
                `UPTIO_REG_CHSEL: next_st.rdata = 32'(st.chsel);
                `UPTIO_REG_CHTAB: next_st.rdata = {24'h00_0000, st.chtab[st.chsel]};
                `UPTIO_REG_RESULT: next_st.rdata = {30'h0000_0000, st.result};
                `UPTIO_REG_SRCPORT: next_st.rdata = {30'h0000_0000, st.srcport};
                `UPTIO_REG_TRIGOUT: next_st.rdata = {30'h0000_0000, st.tout_mode};
                `UPTIO_REG_IRQ_STAT: next_st.rdata = 32'(st.irq_stat);
                `UPTIO_REG_IRQ_MASK: next_st.rdata = 32'(st.irq_mask);
                `UPTIO_REG_MEAS_LEN: next_st.rdata = st.meas_len;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        next_st.ack = req;

        // pin outputs come from flops
        chv = st.chtab[st.chsel];
        next_st.chan = chv[3:0];
        next_st.result = next_st.result;
        if (st.ctrl[`UPTIO_CTRL_ECB]) begin
            next_st.drv = chv[7:4];
        end else begin
            // one-hot active source port, others low
            next_st.drv = next_st.busy ? (4'h1 << st.srcport) : 4'h0;
        end
        unique case (st.tout_mode)
            `UPTIO_TOUT_OFF: next_st.tout = 1'b0;
            `UPTIO_TOUT_BUSY: next_st.tout = next_st.busy;
            `UPTIO_TOUT_READY: next_st.tout = next_st.ready;
            `UPTIO_TOUT_PULSE: next_st.tout = start;
        endcase

        if (sys_rst_i) begin
            next_st = '0;
            next_st.state = uptio_pkg::UPTIO_IDLE;
            next_st.ctrl = `UPTIO_CTRL_RESET;
            next_st.meas_len = `UPTIO_MEAS_LEN_RESET;
            next_st.ready = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = !st.ack;
    assign measure_active_out_o = st.busy;
    assign ready_for_trigger_o = st.ready;
    assign chan_code_o = st.chan;
    assign limit_result_one_o = st.result[0];
    assign limit_result_two_o = st.result[1];
    assign source_port_ind_o = st.drv;
    assign generator_trigger_out_o = st.gen_trig;
    assign coax_trigger_out_o = st.tout;
    assign remote_state_o = st.remote;
    assign irq_o = |(st.irq_stat & st.irq_mask);
endmodule : uptio_top

/* verif/uptio_top_monitor.sv */
// checker for the trigger port: relations between pins, bus and outputs.
// assumes one clock domain and a synchronous reset.
`timescale 1ns/10ps
module uptio_top_monitor #(
    parameter int TRIG_MIN_CYC = 250
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic trigger_input_one_i,
    input wire logic trigger_input_two_i,
    input wire logic coax_trigger_in_i,
    input wire logic generator_handshake_in_i,
    input wire logic measure_active_out_o,
    input wire logic ready_for_trigger_o,
    input wire logic [3:0] chan_code_o,
    input wire logic limit_result_one_o,
    input wire logic limit_result_two_o,
    input wire logic generator_trigger_out_o,
    input wire logic remote_state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    int run_a = 0;
    int run_b = 0;
    logic ok;
    logic wa;
    // runs saturate, so a long pulse stays a valid cause
    always_ff @(posedge clk_i) begin
        run_a <= (trigger_input_one_i || coax_trigger_in_i) ? run_a + (run_a < TRIG_MIN_CYC ? 1 : 0) : 0;
        run_b <= trigger_input_two_i ? run_b + (run_b < TRIG_MIN_CYC ? 1 : 0) : 0;
    end
    assign ok = (run_a >= TRIG_MIN_CYC) || (run_b >= TRIG_MIN_CYC);
    assign wa = avs_write_i && !avs_waitrequest_o;
    property p_excl; !(measure_active_out_o && ready_for_trigger_o); endproperty
    a_excl: assert property (p_excl) else $error("ready while busy");
    property p_done; $fell(measure_active_out_o) |-> ##[0:1] ready_for_trigger_o; endproperty
    a_done: assert property (p_done) else $error("no ready after busy");
    property p_cause; $fell(ready_for_trigger_o) |-> ok || $past(ok) || $past(ok, 2) || wa || $past(wa)
        || $past(wa, 2) || $past(wa, 3); endproperty
    a_cause: assert property (p_cause) else $error("start without cause");
    property p_ghold; generator_trigger_out_o && generator_handshake_in_i |=> generator_trigger_out_o; endproperty
    a_ghold: assert property (p_ghold) else $error("gen trigger dropped early");
    property p_gwait; generator_trigger_out_o && generator_handshake_in_i |-> !measure_active_out_o; endproperty
    a_gwait: assert property (p_gwait) else $error("busy before handshake");
    // the write lands one edge before the waitrequest-low sample, so wa itself is a cause
    property p_lim; $changed({limit_result_two_o, limit_result_one_o}) |-> wa || $past(wa) || $past(wa, 2);
    endproperty
    a_lim: assert property (p_lim) else $error("limit change without write");
    property p_chan; $changed(chan_code_o) |-> wa || $past(wa) || $past(wa, 2); endproperty
    a_chan: assert property (p_chan) else $error("chan change without write");
    property p_rem; $changed(remote_state_o) |-> wa || $past(wa) || $past(wa, 2); endproperty
    a_rem: assert property (p_rem) else $error("remote change without write");
    c_meas: cover property ($rose(measure_active_out_o));
    c_gen: cover property ($rose(generator_trigger_out_o));
    c_rem: cover property ($rose(remote_state_o));
endmodule : uptio_top_monitor
bind uptio_top uptio_top_monitor #(.TRIG_MIN_CYC(TRIG_MIN_CYC)) uptio_top_monitor_i (.clk_i, .sys_rst_i,
    .avs_write_i, .avs_waitrequest_o, .trigger_input_one_i, .trigger_input_two_i, .coax_trigger_in_i,
    .generator_handshake_in_i, .measure_active_out_o, .ready_for_trigger_o, .chan_code_o,
    .limit_result_one_o, .limit_result_two_o, .generator_trigger_out_o, .remote_state_o);

/* verif/uptio_handler_model.sv */
// handler and generator stand-in: trigger pulses on request, handshake answer.
// assumes the bench calls pulse() from its clocked sequence.
`timescale 1ns/10ps
module uptio_handler_model #(
    parameter int HS_CYC = 6
) (
    input wire logic clk_i,
    input wire logic gen_trig_i,
    output logic trig_one_o,
    output logic trig_two_o,
    output logic coax_trig_o,
    output logic handshake_o
);
    logic [2:0] pins = 3'h0;
    int hs_run = 0;
    assign {coax_trig_o, trig_two_o, trig_one_o} = pins;
    // the generator stays busy for its first cycles after each trigger
    assign handshake_o = gen_trig_i && (hs_run < HS_CYC);
    always @(posedge clk_i) hs_run <= gen_trig_i ? hs_run + 1 : 0;
    task automatic pulse(input int sel, input int len);
        @(posedge clk_i);
        pins[sel] <= 1'b1;
        repeat (len) @(posedge clk_i);
        pins[sel] <= 1'b0;
    endtask : pulse
endmodule : uptio_handler_model

/* verif/uptio_top_tb.sv */
// bench for the trigger port: avalon tasks, measurements through the handler model.
// assumes the design header is on the include path.
`timescale 1ns/10ps
`include "uptio_map.svh"
module uptio_top_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic gen_seen = 1'b0;
    logic aux = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdw, rdat;
    logic wreq, busy, rdy, gen, hs, t1, t2, tc, cto, lim1, lim2, rem, irq;
    logic [3:0] chan, src;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    uptio_top #(.TRIG_MIN_CYC(4)) uptio_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdw), .avs_waitrequest_o(wreq), .trigger_input_one_i(t1), .trigger_input_two_i(t2),
        .coax_trigger_in_i(tc), .generator_handshake_in_i(hs), .aux_control_in_a_i(aux),
        .measure_active_out_o(busy), .ready_for_trigger_o(rdy), .chan_code_o(chan), .limit_result_one_o(lim1),
        .limit_result_two_o(lim2), .source_port_ind_o(src), .generator_trigger_out_o(gen),
        .coax_trigger_out_o(cto), .remote_state_o(rem), .irq_o(irq));
    uptio_handler_model uptio_handler_model_i (.clk_i(clk_i), .gen_trig_i(gen), .trig_one_o(t1),
        .trig_two_o(t2), .coax_trig_o(tc), .handshake_o(hs));
    task automatic wrap_up;
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_reg
    task automatic chk_pin(input string nm, input logic [4:0] exp, input logic [4:0] got);
        chk_reg(nm, {27'h0, exp}, {27'h0, got});
    endtask : chk_pin
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr_q <= w;
        rd_q <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        rdat = rdw;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_reg($sformatf("reg_%h", a), exp, rdat);
    endtask : rd
    task automatic meas(input int how, input logic [4:0] exp);
        int n;
        n = 0;
        if (how < 3) uptio_handler_model_i.pulse(how, 4);
        else wr(`UPTIO_REG_CMD, 32'h1);
        while (busy !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
            if (n == 3) chk_pin("busy_pins", exp, {cto, src});
        end
        chk_pin("busy_len", 5'h08, n[4:0]);
        repeat (2) @(posedge clk_i);
        chk_pin("ready_back", 5'h01, {busy, 3'h0, rdy});
    endtask : meas
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        gen_seen <= gen_seen | gen;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk_pin("idle_pins", 5'h01, {busy, 3'h0, rdy});
        rd(`UPTIO_REG_CTRL, `UPTIO_CTRL_RESET);
        rd(`UPTIO_REG_STATUS, 32'h4);
        rd(`UPTIO_REG_MEAS_LEN, `UPTIO_MEAS_LEN_RESET);
        wr(`UPTIO_REG_MEAS_LEN, 32'h8);
        wr(`UPTIO_REG_CHSEL, 32'h3);
        wr(`UPTIO_REG_CHTAB, 32'hA5);
        wr(`UPTIO_REG_TRIGOUT, 32'h1);
        repeat (3) @(posedge clk_i);
        chk_reg("chan_src", 32'hA5, {24'h0, src, chan});
        uptio_handler_model_i.pulse(0, 3);
        repeat (4) @(posedge clk_i);
        chk_pin("short_pulse", 5'h01, {busy, 3'h0, rdy});
        for (int h = 0; h < 3; h++) meas(h, 5'h1A);
        wr(`UPTIO_REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk_pin("irq_on", 5'h01, {4'h0, irq});
        rd(`UPTIO_REG_IRQ_STAT, 32'h3);
        wr(`UPTIO_REG_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        chk_pin("irq_off", 5'h00, {4'h0, irq});
        rd(`UPTIO_REG_IRQ_STAT, 32'h2);
        rd(8'h3C, 32'h0);
        wr(`UPTIO_REG_CTRL, 32'h6);
        wr(`UPTIO_REG_SRCPORT, 32'h2);
        meas(3, 5'h14);
        chk_pin("src_idle", 5'h00, {cto, src});
        wr(`UPTIO_REG_TRIGOUT, 32'h2);
        repeat (2) @(posedge clk_i);
        chk_pin("tout_ready", 5'h01, {4'h0, cto});
        wr(`UPTIO_REG_RESULT, 32'h2);
        repeat (2) @(posedge clk_i);
        chk_pin("limits", 5'h02, {3'h0, lim2, lim1});
        wr(`UPTIO_REG_CMD, 32'h8);
        repeat (2) @(posedge clk_i);
        chk_pin("remote", 5'h01, {4'h0, rem});
        wr(`UPTIO_REG_CMD, 32'h4);
        repeat (2) @(posedge clk_i);
        chk_pin("local", 5'h00, {4'h0, rem});
        wr(`UPTIO_REG_CMD, 32'h2);
        rd(`UPTIO_REG_CHSEL, 32'h0);
        rd(`UPTIO_REG_CTRL, 32'h6);
        aux <= 1'b1;
        rd(`UPTIO_REG_STATUS, 32'h24);
        wr(`UPTIO_REG_CMD, 32'h1);
        wr(`UPTIO_REG_CMD, 32'h10);
        @(posedge clk_i);
        chk_pin("abort", 5'h01, {busy, 3'h0, rdy});
        wr(`UPTIO_REG_TRIGOUT, 32'h1);
        wr(`UPTIO_REG_CTRL, 32'hE);
        meas(3, 5'h14);
        chk_pin("gen_seen", 5'h01, {4'h0, gen_seen});
        wrap_up();
    end
endmodule : uptio_top_tb
